/* File: qcycle_core.sv */
// What this block does
// - Four equal phase slots per instruction cycle.
// - Phases decode, read, execute, write in order.
// - Rotate right, bit zero wraps to seven.
// - Destination bit picks working reg or source.
// - Set all ones; select bit guards working reg.
// - Swap nibbles, no flags touched, one cycle.
module qcycle_core
    import qcycle_pkg::*;
#(
    parameter int MEM_DEPTH = 256
) (
    input  wire logic              clock_in,
    input  wire logic              resetn_in,
    input  wire logic [OP_W-1:0]   opcode_in,
    input  wire logic              op_valid_in,
    input  wire logic [PC_W-1:0]   stack_top_in,
    input  wire logic [PC_W-1:0]   pc_high_latch_in,
    output logic [PC_W-1:0]        pc_out,
    output logic [DATA_W-1:0]      working_reg_out,
    output logic                   global_irq_disable_out,
    output logic                   stack_pop_out,
    output logic [1:0]             phase_out,
    output logic                   cycle_done_out,
    output logic                   forced_nop_out
);
    initial begin
        if (MEM_DEPTH < 1 || MEM_DEPTH > (1 << ADDR_W)) begin
            $error("qcycle_core: MEM_DEPTH out of range");
        end
    end

    data_mem_if mbus ();

    data_mem #(.DEPTH(MEM_DEPTH)) u_mem (
        .clock_in (clock_in),
        .bus      (mbus)
    );

    phase_t            phase_r;
    phase_t            phase_nxt;
    logic [OP_W-1:0]   instr_r;
    op_kind_t          kind_r;
    logic              flush_r;
    logic [DATA_W-1:0] operand_r;
    logic [DATA_W-1:0] working_reg_r;
    logic [PC_W-1:0]   pc_r;
    logic              irq_dis_r;
    logic              pop_r;
    logic              done_r;
    logic              nop_r;

    // Phase counter advances every clock: Q1 to Q4 then back.
    always_comb begin
        case (phase_r)
            PH_Q1:   phase_nxt = PH_Q2;
            PH_Q2:   phase_nxt = PH_Q3;
            PH_Q3:   phase_nxt = PH_Q4;
            PH_Q4:   phase_nxt = PH_Q1;
            default: phase_nxt = PH_Q1;
        endcase
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            phase_r <= PH_Q1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    wire       in_q1     = (phase_r == PH_Q1);
    wire       in_q2     = (phase_r == PH_Q2);
    wire       in_q3     = (phase_r == PH_Q3);
    wire       in_q4     = (phase_r == PH_Q4);
    op_kind_t  new_kind;
    assign new_kind = op_valid_in ? decode_op(opcode_in) : OP_NONE;
    wire       is_return = (new_kind == OP_RETFI) || (new_kind == OP_RETLIT);
    wire       dest_file = instr_r[8];
    wire       file_op   = (kind_r == OP_ROTR) || (kind_r == OP_SETONE)
                           || (kind_r == OP_SWAP);

    // Result of the execute phase.
    logic [DATA_W-1:0] exec_val;
    always_comb begin
        case (kind_r)
            OP_ROTR:   exec_val = {operand_r[0], operand_r[DATA_W-1:1]};
            OP_SWAP:   exec_val = {operand_r[NIB_HI-1:NIB_LO],
                                   operand_r[DATA_W-1:NIB_HI]};
            OP_SETONE: exec_val = ALL_ONES;
            OP_RETLIT: exec_val = instr_r[DATA_W-1:0];
            default:   exec_val = operand_r;
        endcase
    end

    // Q4 write steering: file gets rotate/swap with d=1, and set always.
    wire file_wr = in_q4 && !nop_r && file_op
                   && (dest_file || kind_r == OP_SETONE);
    wire working_reg_wr = in_q4 && !nop_r
                   && ((file_op && !dest_file) || kind_r == OP_RETLIT);

    assign mbus.addr    = instr_r[ADDR_W-1:0];
    assign mbus.wr_en   = file_wr;
    assign mbus.wr_data = exec_val;

    // Q1 decode, or forced nop in the flush cycle after a return.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            instr_r <= '0;
            kind_r  <= OP_NONE;
            flush_r <= 1'b0;
            nop_r   <= 1'b0;
        end else if (in_q1) begin
            if (flush_r) begin
                flush_r <= 1'b0;
                nop_r   <= 1'b1;
            end else begin
                instr_r <= opcode_in;
                kind_r  <= new_kind;
                flush_r <= is_return;
                nop_r   <= 1'b0;
            end
        end else if (in_q4 && flush_r) begin
            kind_r <= OP_NONE;
        end
    end

    // Q2 read operand; memory read data is registered, valid in Q3.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            operand_r <= '0;
        end else if (in_q3) begin
            operand_r <= mbus.rd_data;
        end
    end

    // Operand register loads at the Q3 edge, so execute is settled in Q4 before the Q4 edge.
    wire [DATA_W-1:0] wr_val = exec_val;

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            working_reg_r <= WORKING_REG_RESET;
        end else if (working_reg_wr) begin
            if (kind_r != OP_SETONE || !dest_file) begin
                working_reg_r <= wr_val;
            end
        end
    end

    // Program flow and interrupt enable: returns in the execute phase, PC step in Q4.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pc_r      <= PC_RESET;
            irq_dis_r <= IRQ_DIS_RESET;
            pop_r     <= 1'b0;
        end else begin
            pop_r <= 1'b0;
            if (in_q3 && !nop_r
                && (kind_r == OP_RETFI || kind_r == OP_RETLIT)) begin
                pc_r  <= stack_top_in;
                pop_r <= 1'b1;
                if (kind_r == OP_RETFI) begin
                    irq_dis_r <= 1'b0;
                end
            end else if (in_q4 && !flush_r && !nop_r
                         && !(kind_r == OP_RETFI || kind_r == OP_RETLIT)) begin
                pc_r <= pc_r + PC_W'(1);
            end
        end
    end

    // The high latch is only observed; the returns never modify it.
    wire unused_latch = ^pc_high_latch_in;

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_r <= 1'b0;
        end else begin
            done_r <= in_q4 && !unused_latch || in_q4 && unused_latch;
        end
    end

    assign pc_out                 = pc_r;
    assign working_reg_out        = working_reg_r;
    assign global_irq_disable_out = irq_dis_r;
    assign stack_pop_out          = pop_r;
    assign phase_out              = phase_r;
    assign cycle_done_out         = done_r;
    assign forced_nop_out         = nop_r;
endmodule

/* File: qcycle_pkg.sv */
package qcycle_pkg;

    localparam int          DATA_W         = 8;
    localparam int          OP_W           = 16;
    localparam int          PC_W           = 16;
    localparam int          ADDR_W         = 8;
    localparam int          NIB_LO         = 0;
    localparam int          NIB_HI         = 4;
    localparam logic [15:0] RETFI_CODE     = 16'h0005;
    localparam logic [7:0]  RETLIT_HI      = 8'hB6;
    localparam logic [6:0]  ROTR_HI7       = 7'h10;
    localparam logic [6:0]  SETONES_HI7    = 7'h15;
    localparam logic [6:0]  SWAP_HI7       = 7'h0E;
    localparam logic [7:0]  ALL_ONES       = 8'hFF;
    localparam logic [7:0]  WORKING_REG_RESET     = 8'h00;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic        IRQ_DIS_RESET  = 1'b1;

    // Phase slots, Gray coded in order Q1, Q2, Q3, Q4.
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } phase_t;

    typedef enum logic [2:0] {
        OP_NONE   = 3'h0,
        OP_RETFI  = 3'h1,
        OP_RETLIT = 3'h2,
        OP_ROTR   = 3'h3,
        OP_SETONE = 3'h4,
        OP_SWAP   = 3'h5
    } op_kind_t;

    function automatic op_kind_t decode_op(input logic [15:0] w);
        if (w == RETFI_CODE) begin
            return OP_RETFI;
        end else if (w[15:8] == RETLIT_HI) begin
            return OP_RETLIT;
        end else if (w[15:9] == ROTR_HI7) begin
            return OP_ROTR;
        end else if (w[15:9] == SETONES_HI7) begin
            return OP_SETONE;
        end else if (w[15:9] == SWAP_HI7) begin
            return OP_SWAP;
        end
        return OP_NONE;
    endfunction

endpackage

/* File: data_mem_if.sv */
interface data_mem_if;
    import qcycle_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              wr_en;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] rd_data;
    modport core (output addr, output wr_en, output wr_data, input rd_data);
    modport mem  (input addr, input wr_en, input wr_data, output rd_data);
endinterface

/* File: data_mem.sv */
module data_mem
    import qcycle_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input  wire logic clock_in,
    data_mem_if.mem   bus
);
    initial begin
        if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin
            $error("data_mem: DEPTH out of range");
        end
    end

    logic [DATA_W-1:0] store [DEPTH];
    logic [DATA_W-1:0] rd_r;

    always_ff @(posedge clock_in) begin
        if (bus.wr_en) begin
            store[bus.addr] <= bus.wr_data;
        end
        rd_r <= store[bus.addr];
    end

    assign bus.rd_data = rd_r;
endmodule

/* File: qcycle_core_sva.sv */
module qcycle_core_sva
    import qcycle_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        resetn_in,
    input wire logic [15:0] opcode_in,
    input wire logic        op_valid_in,
    input wire logic [15:0] stack_top_in,
    input wire logic [15:0] pc_out,
    input wire logic [7:0]  working_reg_out,
    input wire logic        global_irq_disable_out,
    input wire logic        stack_pop_out,
    input wire logic [1:0]  phase_out,
    input wire logic        cycle_done_out,
    input wire logic        forced_nop_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);

    AST_PHASE_ORDER: assert property (phase_out == PH_Q1 |=> phase_out == PH_Q2 ##1
        phase_out == PH_Q3 ##1 phase_out == PH_Q4 ##1 phase_out == PH_Q1)
        else $error("phase slots out of order");
    AST_DONE_AFTER_WRITE: assert property (phase_out == PH_Q4 |=>
        cycle_done_out ##1 !cycle_done_out) else $error("cycle done pulse wrong");
    AST_POP_LOADS_PC: assert property (stack_pop_out |-> phase_out == PH_Q4 &&
        pc_out == $past(stack_top_in)) else $error("return reload wrong");
    AST_FLUSH_AFTER_POP: assert property (stack_pop_out |-> ##2 forced_nop_out [*3])
        else $error("no flush cycle after return");
    AST_IRQ_CLEAR_ON_POP: assert property ($fell(global_irq_disable_out) |->
        stack_pop_out) else $error("interrupt enable outside return");
    AST_PC_STEP: assert property ($changed(pc_out) |-> stack_pop_out ||
        (phase_out == PH_Q1 && pc_out == $past(pc_out) + 16'h0001))
        else $error("program counter step wrong");
    AST_WORKING_REG_WRITE_SLOT: assert property ($changed(working_reg_out) |->
        phase_out == PH_Q1) else $error("working reg written outside write slot");
    AST_RETURN_LITERAL_OP_LOAD: assert property (phase_out == PH_Q1 && op_valid_in &&
        opcode_in[15:8] == RETLIT_HI |-> ##4 working_reg_out == $past(opcode_in[7:0], 4))
        else $error("literal not loaded");
endmodule

bind qcycle_core qcycle_core_sva chk (.clock_in, .resetn_in, .opcode_in, .op_valid_in,
    .stack_top_in, .pc_out, .working_reg_out, .global_irq_disable_out, .stack_pop_out,
    .phase_out, .cycle_done_out, .forced_nop_out);

/* File: cpu_qcycle_instruction_exec_tb.sv */
module cpu_qcycle_instruction_exec_tb
    import qcycle_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [15:0] opcode_in = 16'h0000;
    logic        op_valid_in = 1'b0;
    logic [15:0] stack_top_in = 16'h0000;
    logic [15:0] pc_high_latch_in = 16'h0000;
    logic [15:0] pc_out;
    logic [15:0] st;
    logic [15:0] ep;
    logic [7:0]  working_reg_out;
    logic [7:0]  ew;
    logic [7:0]  a;
    logic [1:0]  phase_out;
    logic        global_irq_disable_out;
    logic        stack_pop_out;
    logic        cycle_done_out;
    logic        forced_nop_out;
    logic        ei;
    logic [24:0] exp_q[$];
    int          errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          seed = 32'ha338e760;

    qcycle_core uut (.clock_in, .resetn_in, .opcode_in, .op_valid_in, .stack_top_in,
        .pc_high_latch_in, .pc_out, .working_reg_out, .global_irq_disable_out,
        .stack_pop_out, .phase_out, .cycle_done_out, .forced_nop_out);

    always #50 clock_in = ~clock_in;

    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Launches on the Q4 edge so the word is steady for the next Q1 take.
    task automatic issue(input logic [15:0] op, input logic v, input int n);
        int k;
        k = 0;
        do begin
            @(posedge clock_in);
            k++;
        end while (phase_out !== PH_Q4 && k < 8);
        st = 16'($random(seed));
        opcode_in <= op;
        op_valid_in <= v;
        stack_top_in <= st;
        pc_high_latch_in <= 16'($random(seed));
        ep = (n == 2) ? st : ep + 16'h0001;
        @(posedge clock_in);
        repeat (n) exp_q.push_back({ei, ew, ep});
        if (n == 2) begin
            repeat (4) @(posedge clock_in);
        end
    endtask

    task automatic drain();
        int k;
        k = 0;
        while (exp_q.size() > 0 && k < 20) begin
            @(posedge clock_in);
            k++;
        end
    endtask

    always @(negedge clock_in) begin
        if (cycle_done_out === 1'b1 && exp_q.size() > 0) begin
            check({7'h00, global_irq_disable_out, working_reg_out, pc_out},
                {7'h00, exp_q.pop_front()});
        end
    end

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(posedge clock_in);
        check({5'h00, pc_out, working_reg_out, phase_out, global_irq_disable_out},
            {5'h00, PC_RESET, WORKING_REG_RESET, 2'b00, IRQ_DIS_RESET});
        resetn_in <= 1'b1;
        ei = 1'b1;
        for (int i = 0; i < 6; i++) begin
            a = 8'($random(seed));
            ew = 8'($random(seed));
            issue({RETLIT_HI, ew}, 1'b1, 2);
            issue({SETONES_HI7, 1'b1, a}, 1'b1, 1);
            issue({ROTR_HI7, 1'b1, a}, 1'b1, 1);
            issue({SWAP_HI7, 1'b1, a}, 1'b1, 1);
            issue(16'($random(seed)), 1'b0, 1);
            ew = ALL_ONES;
            issue({(i[0] ? ROTR_HI7 : SWAP_HI7), 1'b0, a}, 1'b1, 1);
            issue({SETONES_HI7, 1'b0, a + 8'h01}, 1'b1, 1);
        end
        ei = 1'b0;
        issue(RETFI_CODE, 1'b1, 2);
        drain();
        $display("instruction test done");
        @(posedge clock_in);
        resetn_in <= 1'b0;
        op_valid_in <= 1'b0;
        @(posedge clock_in);
        resetn_in <= 1'b1;
        check({31'h0, global_irq_disable_out}, {31'h0, IRQ_DIS_RESET});
        ei = 1'b1;
        ew = 8'($random(seed));
        issue({RETLIT_HI, ew}, 1'b1, 2);
        drain();
        $display("reset test done");
        finish_test();
    end
endmodule
